// ==== timer16_pkg.sv ====
/*
 * Shared constants and types for the 16-bit timer register block:
 * I/O offsets, field positions, top values and the small types that
 * travel between the register block and its waveform channels.
 * Assumes an 8-bit I/O data path with a 6-bit I/O address.
 */
package timer16_pkg;

    // ------------------------------------------------------------
    // I/O offsets
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_FLAGS = 6'h0B;
    localparam logic [5:0] ADDR_ENABLES = 6'h0C;
    localparam logic [5:0] ADDR_FORCE = 6'h22;
    localparam logic [5:0] ADDR_CAPTURE_LO = 6'h24;
    localparam logic [5:0] ADDR_CAPTURE_HI = 6'h25;
    localparam logic [5:0] ADDR_CMPB_LO = 6'h28;
    localparam logic [5:0] ADDR_CMPB_HI = 6'h29;
    localparam logic [5:0] ADDR_CMPA_LO = 6'h2A;
    localparam logic [5:0] ADDR_CMPA_HI = 6'h2B;
    localparam logic [5:0] ADDR_COUNT_LO = 6'h2C;
    localparam logic [5:0] ADDR_COUNT_HI = 6'h2D;
    localparam logic [5:0] ADDR_CTRL_B = 6'h2E;
    localparam logic [5:0] ADDR_CTRL_A = 6'h2F;

    // ------------------------------------------------------------
    // field positions and masks
    // ------------------------------------------------------------
    localparam int BIT_CAPTURE = 5;
    localparam int BIT_CMPB = 2;
    localparam int BIT_CMPA = 1;
    localparam int BIT_OVF = 0;
    localparam logic [7:0] FLAG_MASK = 8'h27;
    localparam int FORCE_A_BIT = 7;
    localparam int FORCE_B_BIT = 6;
    localparam logic [7:0] CTRL_A_MASK = 8'hF3;
    localparam logic [7:0] CTRL_B_MASK = 8'hDF;
    localparam int CTRLA_COMA_LSB = 6;
    localparam int CTRLA_COMB_LSB = 4;
    localparam int CTRLB_NOISE_BIT = 7;
    localparam int CTRLB_EDGE_BIT = 6;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [2:0] CLOCK_STOPPED = 3'h0;

    // ------------------------------------------------------------
    // counter limits and mode codes
    // ------------------------------------------------------------
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam int NOISE_SAMPLES = 4;

    localparam logic [1:0] COM_OFF = 2'b00;
    localparam logic [1:0] COM_TOGGLE = 2'b01;
    localparam logic [1:0] COM_CLEAR = 2'b10;
    localparam logic [1:0] COM_SET = 2'b11;

    typedef enum logic {COUNT_UP = 1'b0, COUNT_DOWN = 1'b1} count_dir_t;

    typedef enum logic [1:0] {
        WAVE_SINGLE = 2'b00,
        WAVE_FAST = 2'b01,
        WAVE_DUAL = 2'b11
    } wave_kind_t;

    // counter state seen by each waveform channel
    typedef struct packed {
        wave_kind_t kind;
        count_dir_t dir;
        logic modeHigh;
        logic bottomTick;
    } count_state_t;

endpackage

// ==== wave_channel.sv ====
/*
 * One waveform output channel: applies the compare output mode to
 * compare matches and forced strobes.
 * Assumes match and force are one-cycle pulses from the register block.
 */
`timescale 1ns/100ps
`default_nettype none

module wave_channel #(
    parameter bit IS_CHANNEL_A = 1'b1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire timer16_pkg::count_state_t countState,
    input wire logic [1:0] outMode,
    input wire logic match,
    input wire logic forceHit,
    output var logic waveOut
);

    // ------------------------------------------------------------
    // output flip-flop
    // ------------------------------------------------------------
    // force uses whatever mode is set now, exactly like a real match
    always_ff @(posedge clk) begin
        if (!resetn) begin
            waveOut <= 1'b0;
        end else if (match || forceHit) begin
            unique case (countState.kind)
                timer16_pkg::WAVE_SINGLE: begin
                    if (outMode == timer16_pkg::COM_TOGGLE) waveOut <= ~waveOut;
                    else if (outMode == timer16_pkg::COM_CLEAR) waveOut <= 1'b0;
                    else if (outMode == timer16_pkg::COM_SET) waveOut <= 1'b1;
                end
                timer16_pkg::WAVE_FAST: begin
                    // toggle only exists for channel a with mode bit 3 set: capture or compare-a top
                    if (outMode == timer16_pkg::COM_TOGGLE) begin
                        if (IS_CHANNEL_A && countState.modeHigh) waveOut <= ~waveOut;
                    end else if (outMode == timer16_pkg::COM_CLEAR) waveOut <= 1'b0;
                    else if (outMode == timer16_pkg::COM_SET) waveOut <= 1'b1;
                end
                timer16_pkg::WAVE_DUAL: begin
                    if (outMode == timer16_pkg::COM_TOGGLE) begin
                        if (IS_CHANNEL_A && countState.modeHigh) waveOut <= ~waveOut;
                    end else if (outMode == timer16_pkg::COM_CLEAR) begin
                        waveOut <= (countState.dir == timer16_pkg::COUNT_DOWN);
                    end else if (outMode == timer16_pkg::COM_SET) begin
                        waveOut <= (countState.dir == timer16_pkg::COUNT_UP);
                    end
                end
                default: waveOut <= waveOut;
            endcase
        end else if (countState.kind == timer16_pkg::WAVE_FAST && countState.bottomTick) begin
            // fast pwm restores the level at bottom
            if (outMode == timer16_pkg::COM_CLEAR) waveOut <= 1'b1;
            else if (outMode == timer16_pkg::COM_SET) waveOut <= 1'b0;
        end
    end

endmodule // wave_channel

`default_nettype wire

// ==== timer16_regs.sv ====
/*
 * Register side of the 16-bit timer: counter, compare, capture,
 * shared high-byte latch, flags, enables and force strobes.
 * Assumes a synchronous 8-bit I/O port from the core, one access per
 * cycle, and synchronous pin inputs.
 */
// How it works
// - force strobes act only in non-pwm modes
// - force makes immediate match on waveform output
// - force raises no interrupt, never clears counter
// - force strobe bits always read zero
// - reserved bits read as zero
// - counter accessed atomically through shared latch
// - compare and capture share that latch
// - counter write blocks next compare match
// - compare registers compared continuously with counter
// - capture event loads counter into capture
// - capture register can serve as top
// - interrupt requested when enable, global, flag set
// - flag register layout at offset 0x0b
// - capture flag on event, or at capture top
// - compare flag set cycle after equality
// - force strobe never sets compare flag
// - overflow flag point follows waveform mode
// - flags clear on vector or write one
// - enables, flags, capture reset to zero
// - capture pin disconnected while capture is top
// - edge select: zero falling, one rising
`timescale 1ns/100ps
`default_nettype none

module timer16_regs #(
    parameter int NOISE_LEN = timer16_pkg::NOISE_SAMPLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] ioAddr,
    input wire logic [7:0] ioWrData,
    input wire logic ioWrite,
    input wire logic ioRead,
    output var logic [7:0] ioRdData,
    input wire logic capturePin,
    input wire logic comparatorOut,
    input wire logic captureFromComparator,
    input wire logic globalIrqEnable,
    input wire logic [3:0] vectorAck,
    output var logic [3:0] irqRequest,
    output var logic waveOutA,
    output var logic waveOutB
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0] counter;
    logic [15:0] capture;
    logic [15:0] compare [2];
    logic [7:0] temp;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    timer16_pkg::count_dir_t dir;
    logic blockMatch;
    logic [1:0] matchPulse;
    logic [1:0] forceNow;
    logic overflowTick;
    logic topTick;
    logic bottomTick;
    logic [NOISE_LEN-1:0] samples;
    logic captureLevel;
    logic capturePrev;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic [3:0] waveMode;
    logic [15:0] top;
    timer16_pkg::wave_kind_t kind;
    logic captureIsTop;
    logic singleSlopeWrap;
    logic countRun;
    logic [7:0] next_flags;
    logic [7:0] flagSet;
    logic [7:0] flagClear;
    logic [1:0] matchNow;
    logic captureEdge;
    logic captureSource;
    logic samplesEqual;

    assign waveMode = {ctrlB[4:3], ctrlA[1:0]};
    assign countRun = (ctrlB[2:0] != timer16_pkg::CLOCK_STOPPED);

    // top value, slope kind and capture-as-top per mode
    always_comb begin
        top = timer16_pkg::COUNT_MAX;
        kind = timer16_pkg::WAVE_SINGLE;
        captureIsTop = 1'b0;
        unique case (waveMode)
            4'h1, 4'h2, 4'h3: kind = timer16_pkg::WAVE_DUAL;
            4'h5, 4'h6, 4'h7: kind = timer16_pkg::WAVE_FAST;
            4'h8, 4'hA: begin
                kind = timer16_pkg::WAVE_DUAL;
                captureIsTop = 1'b1;
            end
            4'h9, 4'hB: kind = timer16_pkg::WAVE_DUAL;
            4'hC: captureIsTop = 1'b1;
            4'hE: begin
                kind = timer16_pkg::WAVE_FAST;
                captureIsTop = 1'b1;
            end
            4'hF: kind = timer16_pkg::WAVE_FAST;
            default: kind = timer16_pkg::WAVE_SINGLE;
        endcase
        unique case (waveMode)
            4'h1, 4'h5: top = timer16_pkg::TOP_8BIT;
            4'h2, 4'h6: top = timer16_pkg::TOP_9BIT;
            4'h3, 4'h7: top = timer16_pkg::TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top = compare[0];
            4'h8, 4'hA, 4'hC, 4'hE: top = capture;
            default: top = timer16_pkg::COUNT_MAX;
        endcase
    end

    // normal and clear-on-match modes set overflow at max, not top
    assign singleSlopeWrap = (kind == timer16_pkg::WAVE_SINGLE);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrlA <= timer16_pkg::RESET_BYTE;
            ctrlB <= timer16_pkg::RESET_BYTE;
            enables <= timer16_pkg::RESET_BYTE;
        end else if (ioWrite) begin
            if (ioAddr == timer16_pkg::ADDR_CTRL_A) ctrlA <= ioWrData & timer16_pkg::CTRL_A_MASK;
            if (ioAddr == timer16_pkg::ADDR_CTRL_B) ctrlB <= ioWrData & timer16_pkg::CTRL_B_MASK;
            if (ioAddr == timer16_pkg::ADDR_ENABLES) begin
                enables <= ioWrData & timer16_pkg::FLAG_MASK;
            end
        end
    end

    // force strobes never stored, only pulsed in non-pwm modes
    assign forceNow[0] = ioWrite && ioAddr == timer16_pkg::ADDR_FORCE
        && ioWrData[timer16_pkg::FORCE_A_BIT] && kind == timer16_pkg::WAVE_SINGLE;
    assign forceNow[1] = ioWrite && ioAddr == timer16_pkg::ADDR_FORCE
        && ioWrData[timer16_pkg::FORCE_B_BIT] && kind == timer16_pkg::WAVE_SINGLE;

    // ------------------------------------------------------------
    // shared high-byte latch
    // ------------------------------------------------------------
    // one latch for all wide registers: an interrupt handler touching
    // another wide register between the two bytes corrupts the access
    always_ff @(posedge clk) begin
        if (!resetn) begin
            temp <= timer16_pkg::RESET_BYTE;
        end else if (ioWrite && (ioAddr == timer16_pkg::ADDR_COUNT_HI
                || ioAddr == timer16_pkg::ADDR_CMPA_HI || ioAddr == timer16_pkg::ADDR_CMPB_HI
                || ioAddr == timer16_pkg::ADDR_CAPTURE_HI)) begin
            temp <= ioWrData;
        end else if (ioRead) begin
            unique case (ioAddr)
                timer16_pkg::ADDR_COUNT_LO: temp <= counter[15:8];
                timer16_pkg::ADDR_CMPA_LO: temp <= compare[0][15:8];
                timer16_pkg::ADDR_CMPB_LO: temp <= compare[1][15:8];
                timer16_pkg::ADDR_CAPTURE_LO: temp <= capture[15:8];
                default: temp <= temp;
            endcase
        end
    end

    // ------------------------------------------------------------
    // counter and direction
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            counter <= timer16_pkg::RESET_WORD;
        end else if (ioWrite && ioAddr == timer16_pkg::ADDR_COUNT_LO) begin
            counter <= {temp, ioWrData};
        end else if (countRun) begin
            // the counter only sees its own top, never a force strobe
            if (kind == timer16_pkg::WAVE_DUAL) begin
                if (dir == timer16_pkg::COUNT_UP && counter != top) counter <= counter + timer16_pkg::COUNT_ONE;
                else if (dir == timer16_pkg::COUNT_DOWN && counter == timer16_pkg::COUNT_BOTTOM) counter <= counter + timer16_pkg::COUNT_ONE;
                else counter <= counter - timer16_pkg::COUNT_ONE;
            end else if (counter == top) begin
                counter <= timer16_pkg::COUNT_BOTTOM;
            end else begin
                counter <= counter + timer16_pkg::COUNT_ONE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            dir <= timer16_pkg::COUNT_UP;
        end else if (kind != timer16_pkg::WAVE_DUAL) begin
            dir <= timer16_pkg::COUNT_UP;
        end else if (countRun) begin
            if (dir == timer16_pkg::COUNT_UP && counter == top) dir <= timer16_pkg::COUNT_DOWN;
            else if (dir == timer16_pkg::COUNT_DOWN && counter == timer16_pkg::COUNT_BOTTOM) dir <= timer16_pkg::COUNT_UP;
        end
    end

    // ------------------------------------------------------------
    // compare units
    // ------------------------------------------------------------
    // a counter write holds off matches until the next timer tick has passed
    always_ff @(posedge clk) begin
        if (!resetn) begin
            blockMatch <= 1'b0;
        end else if (ioWrite && ioAddr == timer16_pkg::ADDR_COUNT_LO) begin
            blockMatch <= 1'b1;
        end else if (countRun) begin
            blockMatch <= 1'b0;
        end
    end

    for (genvar ch = 0; ch < 2; ch++) begin : gen_compare
        localparam logic [5:0] LO = (ch == 0) ? timer16_pkg::ADDR_CMPA_LO : timer16_pkg::ADDR_CMPB_LO;
        assign matchNow[ch] = countRun && !blockMatch && counter == compare[ch];
        always_ff @(posedge clk) begin
            if (!resetn) begin
                compare[ch] <= timer16_pkg::RESET_WORD;
                matchPulse[ch] <= 1'b0;
            end else begin
                if (ioWrite && ioAddr == LO) compare[ch] <= {temp, ioWrData};
                matchPulse[ch] <= matchNow[ch];
            end
        end
    end

    // ------------------------------------------------------------
    // counter events
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            overflowTick <= 1'b0;
            topTick <= 1'b0;
            bottomTick <= 1'b0;
        end else begin
            topTick <= countRun && counter == top && dir == timer16_pkg::COUNT_UP;
            bottomTick <= countRun && counter == top && kind == timer16_pkg::WAVE_FAST;
            if (singleSlopeWrap) begin
                overflowTick <= countRun && counter == timer16_pkg::COUNT_MAX;
            end else if (kind == timer16_pkg::WAVE_FAST) begin
                overflowTick <= countRun && counter == top;
            end else begin
                overflowTick <= countRun && dir == timer16_pkg::COUNT_DOWN
                    && counter == timer16_pkg::COUNT_BOTTOM;
            end
        end
    end

    // ------------------------------------------------------------
    // capture input
    // ------------------------------------------------------------
    assign captureSource = captureFromComparator ? comparatorOut : capturePin;
    assign samplesEqual = (&samples) || !(|samples);

    // optional filter: the level moves only after NOISE_LEN equal samples
    always_ff @(posedge clk) begin
        if (!resetn) begin
            samples <= '0;
            captureLevel <= 1'b0;
            capturePrev <= 1'b0;
        end else begin
            samples <= {samples[NOISE_LEN-2:0], captureSource};
            if (!ctrlB[timer16_pkg::CTRLB_NOISE_BIT]) captureLevel <= captureSource;
            else if (samplesEqual) captureLevel <= samples[NOISE_LEN-1];
            capturePrev <= captureLevel;
        end
    end

    assign captureEdge = !captureIsTop && (captureLevel != capturePrev)
        && (captureLevel == ctrlB[timer16_pkg::CTRLB_EDGE_BIT]);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            capture <= timer16_pkg::RESET_WORD;
        end else if (ioWrite && ioAddr == timer16_pkg::ADDR_CAPTURE_LO) begin
            capture <= {temp, ioWrData};
        end else if (captureEdge) begin
            capture <= counter;
        end
    end

    // ------------------------------------------------------------
    // flags and interrupt requests
    // ------------------------------------------------------------
    // a set in the same cycle as a clear wins, so no event is lost
    always_comb begin
        flagSet = timer16_pkg::RESET_BYTE;
        flagClear = timer16_pkg::RESET_BYTE;
        flagSet[timer16_pkg::BIT_OVF] = overflowTick;
        flagSet[timer16_pkg::BIT_CMPA] = matchPulse[0];
        flagSet[timer16_pkg::BIT_CMPB] = matchPulse[1];
        flagSet[timer16_pkg::BIT_CAPTURE] = captureIsTop ? topTick : captureEdge;
        flagClear[timer16_pkg::BIT_OVF] = vectorAck[0];
        flagClear[timer16_pkg::BIT_CMPA] = vectorAck[1];
        flagClear[timer16_pkg::BIT_CMPB] = vectorAck[2];
        flagClear[timer16_pkg::BIT_CAPTURE] = vectorAck[3];
        if (ioWrite && ioAddr == timer16_pkg::ADDR_FLAGS) flagClear = flagClear | ioWrData;
        next_flags = ((flags & ~flagClear) | flagSet) & timer16_pkg::FLAG_MASK;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flags <= timer16_pkg::RESET_BYTE;
        end else begin
            flags <= next_flags;
        end
    end

    // force strobes feed only the wave channels, so no request comes of them
    always_ff @(posedge clk) begin
        if (!resetn) begin
            irqRequest <= 4'h0;
        end else begin
            irqRequest[0] <= globalIrqEnable && (flags[timer16_pkg::BIT_OVF] & enables[timer16_pkg::BIT_OVF]);
            irqRequest[1] <= globalIrqEnable && (flags[timer16_pkg::BIT_CMPA] & enables[timer16_pkg::BIT_CMPA]);
            irqRequest[2] <= globalIrqEnable && (flags[timer16_pkg::BIT_CMPB] & enables[timer16_pkg::BIT_CMPB]);
            irqRequest[3] <= globalIrqEnable && (flags[timer16_pkg::BIT_CAPTURE] & enables[timer16_pkg::BIT_CAPTURE]);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ioRdData <= timer16_pkg::RESET_BYTE;
        end else if (ioRead) begin
            unique case (ioAddr)
                timer16_pkg::ADDR_FLAGS: ioRdData <= flags;
                timer16_pkg::ADDR_ENABLES: ioRdData <= enables;
                timer16_pkg::ADDR_FORCE: ioRdData <= timer16_pkg::RESET_BYTE;
                timer16_pkg::ADDR_CTRL_A: ioRdData <= ctrlA;
                timer16_pkg::ADDR_CTRL_B: ioRdData <= ctrlB;
                timer16_pkg::ADDR_COUNT_LO: ioRdData <= counter[7:0];
                timer16_pkg::ADDR_CMPA_LO: ioRdData <= compare[0][7:0];
                timer16_pkg::ADDR_CMPB_LO: ioRdData <= compare[1][7:0];
                timer16_pkg::ADDR_CAPTURE_LO: ioRdData <= capture[7:0];
                timer16_pkg::ADDR_COUNT_HI, timer16_pkg::ADDR_CMPA_HI,
                timer16_pkg::ADDR_CMPB_HI, timer16_pkg::ADDR_CAPTURE_HI: ioRdData <= temp;
                default: ioRdData <= timer16_pkg::RESET_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // waveform channels
    // ------------------------------------------------------------
    timer16_pkg::count_state_t countState;
    assign countState = '{kind: kind, dir: dir, modeHigh: waveMode[3], bottomTick: bottomTick};

    wave_channel #(.IS_CHANNEL_A(1'b1)) u_wave_a (
        .clk(clk),
        .resetn(resetn),
        .countState(countState),
        .outMode(ctrlA[timer16_pkg::CTRLA_COMA_LSB +: 2]),
        .match(matchPulse[0]),
        .forceHit(forceNow[0]),
        .waveOut(waveOutA)
    );

    wave_channel #(.IS_CHANNEL_A(1'b0)) u_wave_b (
        .clk(clk),
        .resetn(resetn),
        .countState(countState),
        .outMode(ctrlA[timer16_pkg::CTRLA_COMB_LSB +: 2]),
        .match(matchPulse[1]),
        .forceHit(forceNow[1]),
        .waveOut(waveOutB)
    );

endmodule // timer16_regs

`default_nettype wire

// ==== timer16_regs_asserts.sv ====
/* port checks for timer16_regs.
   assumes one clock clk and a synchronous active-low resetn. */
`timescale 1ns/100ps
`default_nettype none
module timer16_regs_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] ioAddr,
    input wire logic ioRead,
    input wire logic [7:0] ioRdData,
    input wire logic globalIrqEnable,
    input wire logic [3:0] vectorAck,
    input wire logic [3:0] irqRequest
);
    // one domain, so clock and reset are stated once
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_frc; ioRead && ioAddr == 6'h22 |=> ioRdData == 8'h00; endproperty
    a_frc: assert property (p_frc) else $error("force bits read back");
    property p_flg; ioRead && ioAddr == 6'h0B |=> (ioRdData & 8'hD8) == 8'h00; endproperty
    a_flg: assert property (p_flg) else $error("flag spare bits");
    property p_ena; ioRead && ioAddr == 6'h0C |=> (ioRdData & 8'hD8) == 8'h00; endproperty
    a_ena: assert property (p_ena) else $error("enable spare bits");
    property p_unm; ioRead && ioAddr == 6'h3F |=> ioRdData == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    // read data must not drift between reads, or a split word tears
    property p_hold; !ioRead |=> $stable(ioRdData); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_glb; irqRequest != 4'h0 |-> $past(globalIrqEnable); endproperty
    a_glb: assert property (p_glb) else $error("request without global");
    property p_off; !globalIrqEnable |=> irqRequest == 4'h0; endproperty
    a_off: assert property (p_off) else $error("request while masked");
    property p_ack; vectorAck[1] |=> ##1 !irqRequest[1]; endproperty
    a_ack: assert property (p_ack) else $error("ack left request");
endmodule // timer16_regs_asserts
bind timer16_regs timer16_regs_asserts chk_i (.clk(clk), .resetn(resetn), .ioAddr(ioAddr),
    .ioRead(ioRead), .ioRdData(ioRdData), .globalIrqEnable(globalIrqEnable),
    .vectorAck(vectorAck), .irqRequest(irqRequest));
`default_nettype wire

// ==== core_irq_model.sv ====
/* core stand-in that runs pending timer vectors.
   assumes irqRequest is a registered level. */
`timescale 1ns/100ps
`default_nettype none
module core_irq_model (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ackOn,
    input wire logic [3:0] irqRequest,
    output var logic [3:0] vectorAck
);
    logic ackGap;

    // one ack pulse, then two quiet cycles: the request drops two edges after the ack
    always_ff @(posedge clk) begin
        ackGap <= resetn && vectorAck != 4'h0;
        if (!resetn || !ackOn || vectorAck != 4'h0 || ackGap) begin
            vectorAck <= 4'h0;
        end else begin
            vectorAck <= irqRequest;
        end
    end
endmodule // core_irq_model
`default_nettype wire

// ==== tb_timer16_regs.sv ====
/* self-checking bench for timer16_regs through its I/O port.
   assumes the core stand-in acks vectors only while ackOn is set. */
`timescale 1ns/100ps
`default_nettype none
module tb_timer16_regs;
    logic clk = 1'b0, resetn = 1'b0, ioWrite = 1'b0, ioRead = 1'b0, capturePin = 1'b1;
    logic globalIrqEnable = 1'b0, ackOn = 1'b0, waveOutA, waveOutB;
    logic [5:0] ioAddr = 6'h00;
    logic [7:0] ioWrData = 8'h00, ioRdData;
    logic [3:0] vectorAck, irqRequest;
    int n_fail = 0, n_checks = 0;
    always #20 clk = ~clk;
    timer16_regs dut (.clk(clk), .resetn(resetn), .ioAddr(ioAddr), .ioWrData(ioWrData),
        .ioWrite(ioWrite), .ioRead(ioRead), .ioRdData(ioRdData), .capturePin(capturePin),
        .comparatorOut(1'b0), .captureFromComparator(1'b0), .globalIrqEnable(globalIrqEnable),
        .vectorAck(vectorAck), .irqRequest(irqRequest), .waveOutA(waveOutA), .waveOutB(waveOutB));
    core_irq_model core (.clk(clk), .resetn(resetn), .ackOn(ackOn), .irqRequest(irqRequest),
        .vectorAck(vectorAck));
    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one strobe per access, idle cycle between so strobes never merge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk) {ioAddr, ioWrData, ioWrite} = {a, d, 1'b1};
        @(negedge clk) ioWrite = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(negedge clk) {ioAddr, ioRead} = {a, 1'b1};
        @(negedge clk) ioRead = 1'b0;
        chk(ioRdData, exp);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog, far beyond the at most 162 cycles the tests need
    initial begin
        #100000;
        n_fail++;
        end_of_test;
    end
    initial begin
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        rd(6'h0C, 8'h00);
        wr(6'h0C, 8'hFF);
        rd(6'h0C, 8'h27);
        wr(6'h0B, 8'hFF);
        rd(6'h0B, 8'h00);
        rd(6'h3F, 8'h00);
        wr(6'h2D, 8'h12);
        wr(6'h2C, 8'h34);
        rd(6'h2C, 8'h34);
        rd(6'h2D, 8'h12);
        rd(6'h24, 8'h00);
        rd(6'h2D, 8'h00);
        wr(6'h2B, 8'h00);
        wr(6'h2A, 8'h40);
        wr(6'h2F, 8'h50);
        wr(6'h22, 8'hC0);
        rd(6'h22, 8'h00);
        chk({7'h00, waveOutA}, 8'h01);
        chk({7'h00, waveOutB}, 8'h01);
        rd(6'h0B, 8'h00);
        // strobe in pwm mode must leave the output alone; clear mode would pull it low
        wr(6'h2F, 8'h81);
        wr(6'h22, 8'h80);
        wr(6'h2F, 8'h50);
        rd(6'h0B, 8'h00);
        chk({7'h00, waveOutA}, 8'h01);
        // running counter written onto the compare value: that match is dropped
        wr(6'h2E, 8'h01);
        wr(6'h2D, 8'h00);
        wr(6'h2C, 8'h40);
        rd(6'h0B, 8'h00);
        wr(6'h2C, 8'h30);
        repeat (30) @(negedge clk);
        rd(6'h0B, 8'h02);
        wr(6'h0B, 8'h02);
        rd(6'h0B, 8'h00);
        {globalIrqEnable, ackOn} = 2'b11;
        wr(6'h2C, 8'h30);
        for (int i = 0; i < 40 && irqRequest[1] !== 1'b1; i++) @(negedge clk);
        chk({7'h00, irqRequest[1]}, 8'h01);
        repeat (4) @(negedge clk);
        chk({7'h00, irqRequest[1]}, 8'h00);
        rd(6'h0B, 8'h00);
        // stopped counter, falling pin edge with edge select zero
        {globalIrqEnable, ackOn} = 2'b00;
        wr(6'h2E, 8'h00);
        wr(6'h2D, 8'h5A);
        wr(6'h2C, 8'h5A);
        capturePin = 1'b0;
        repeat (2) @(negedge clk);
        rd(6'h24, 8'h5A);
        rd(6'h25, 8'h5A);
        rd(6'h0B, 8'h20);
        end_of_test;
    end
endmodule // tb_timer16_regs
`default_nettype wire
